// file: rtl/oscc_top.sv
// Purpose: oscillator source control with keyed write lock and primary fail-over
// Assumes: one 20 MHz clock; oscillator states arrive as synchronous levels
// Notes: the failure event is a held level until software rewrites the control register
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - control register unlocks only after key e7 then key 18 written.
// - write while unlocked updates control and relocks at once.
// - control writes without full unlock leave the settings unchanged.
// - reads and other register accesses do not disturb unlock progress.
// - detectors may be re-enabled any time after a successful select write.
// - precision oscillator is enabled after reset with no software action.
// - precision oscillator stays on until software clears its enable.
// - primary failure with detection enabled raises a clock failure event.
// - detected primary failure switches system clock to watchdog oscillator.
// - fail-over only when watchdog oscillator enabled; reset function irrelevant.
// - no fail-over when watchdog oscillator is already selected.
// - failure flagged when primary clock falls below about 500 Hz (either edge restarts the 1 ms window).
module oscc_top #(
  parameter int TRIP = oscc_pkg::TRIP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic primary_osc_i,
  input wire logic wdog_osc_ok_i,
  output logic [1:0] clock_source_select_o,
  output logic internal_precision_osc_en_o,
  output logic primary_osc_en_o,
  output logic wdog_osc_en_o,
  output logic clock_fail_event_o
);
  logic [7:0] osc_source_control_reg;
  logic [31:0] scratch;
  oscc_pkg::oscc_lock_t lock_state;
  logic failed;
  logic failover;
  logic [7:0] next_ctrl;
  logic [31:0] next_scratch;
  oscc_pkg::oscc_lock_t next_lock;
  logic next_failed;
  logic next_failover;
  logic [31:0] next_rdata;
  logic next_ack;
  logic detect_fail;
  logic bus_req;
  logic ctrl_wr;
  logic primary_fail_detect_enable;
  logic wdog_osc_fail_detect_enable;
  logic [1:0] clock_source_select;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // only the low byte lane carries the control value
  assign ctrl_wr = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == oscc_pkg::CTRL_ADDR);
  assign primary_fail_detect_enable = osc_source_control_reg[oscc_pkg::POF_EN_BIT];
  assign wdog_osc_fail_detect_enable = osc_source_control_reg[oscc_pkg::WOF_EN_BIT];
  assign clock_source_select = osc_source_control_reg[oscc_pkg::SEL_LSB +: 2];

  oscc_edge_watch #(
    .TRIP(TRIP)
  ) u_watch (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .enable_i(primary_fail_detect_enable),
    .osc_i(primary_osc_i),
    .fail_o(detect_fail)
  );

  // assertion helper: quiet span at the pin, counted apart from the watch
  // it keeps counting past the trip point so a late or early trip both show up
  logic seen_osc;
  logic next_seen_osc;
  logic [24:0] quiet_span;
  logic [24:0] next_quiet_span;

  always_comb begin
    next_seen_osc = primary_osc_i;
    next_quiet_span = quiet_span;
    if (!primary_fail_detect_enable || (primary_osc_i != seen_osc)) begin
      next_quiet_span = '0;
    end else if (quiet_span != '1) begin
      next_quiet_span = quiet_span + 25'h1;  // saturates, never wraps
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seen_osc <= 1'b0;
      quiet_span <= '0;
    end else begin
      seen_osc <= next_seen_osc;
      quiet_span <= next_quiet_span;
    end
  end

  // unlock sequencer and control register
  always_comb begin
    next_lock = lock_state;
    next_ctrl = osc_source_control_reg;
    if (ctrl_wr) begin
      case (lock_state)
        oscc_pkg::LOCK_IDLE: begin
          next_lock = (wb_dat_i[7:0] == oscc_pkg::KEY_FIRST) ? oscc_pkg::LOCK_KEY1 : oscc_pkg::LOCK_IDLE;
        end
        // wrong second value drops progress, a repeat first key stays armed
        oscc_pkg::LOCK_KEY1: begin
          if (wb_dat_i[7:0] == oscc_pkg::KEY_SECOND) begin
            next_lock = oscc_pkg::LOCK_OPEN;
          end else if (wb_dat_i[7:0] == oscc_pkg::KEY_FIRST) begin
            next_lock = oscc_pkg::LOCK_KEY1;
          end else begin
            next_lock = oscc_pkg::LOCK_IDLE;
          end
        end
        // effective write then relock; software alone sets enables
        oscc_pkg::LOCK_OPEN: begin
          next_ctrl = wb_dat_i[7:0];
          next_lock = oscc_pkg::LOCK_IDLE;
        end
        default: begin
          next_lock = oscc_pkg::LOCK_IDLE;
        end
      endcase
    end
    // other accesses leave lock_state as it is
  end

  always_comb begin
    next_failed = failed;
    next_failover = failover;
    if (ctrl_wr && lock_state == oscc_pkg::LOCK_OPEN) begin
      next_failed = 1'b0;  // a fresh source choice clears the recovery
      next_failover = 1'b0;
    end
    // the detector wins over a simultaneous clear so no failure is lost
    if (detect_fail && primary_fail_detect_enable) begin
      next_failed = 1'b1;
      if (osc_source_control_reg[oscc_pkg::WDO_EN_BIT] && clock_source_select != oscc_pkg::SRC_WDOG) begin
        next_failover = 1'b1;
      end
    end
  end

  // bus slave: one-cycle ack, unmapped reads return zero and writes drop
  always_comb begin
    next_ack = bus_req;
    next_scratch = scratch;
    next_rdata = '0;
    if (bus_req) begin
      case (wb_adr_i)
        oscc_pkg::CTRL_ADDR: begin
          next_rdata = {24'h0, osc_source_control_reg};
        end
        oscc_pkg::STAT_ADDR: begin
          next_rdata[oscc_pkg::ST_FAILOVER_BIT] = failover;
          next_rdata[oscc_pkg::ST_UNLOCK_LSB +: 2] = lock_state;
          next_rdata[oscc_pkg::ST_FAIL_BIT] = failed;
        end
        oscc_pkg::SCRATCH_ADDR: begin
          next_rdata = scratch;
          if (wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
              if (wb_sel_i[b]) begin
                next_scratch[b*8 +: 8] = wb_dat_i[b*8 +: 8];
              end
            end
          end
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // reset state: precision osc on and selected, locked
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_source_control_reg <= oscc_pkg::CTRL_RESET;
      lock_state <= oscc_pkg::LOCK_IDLE;
      scratch <= '0;
      failed <= 1'b0;
      failover <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      osc_source_control_reg <= next_ctrl;
      lock_state <= next_lock;
      scratch <= next_scratch;
      failed <= next_failed;
      failover <= next_failover;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  // outputs registered; fail-over overrides the select and keeps watchdog osc on
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      clock_source_select_o <= oscc_pkg::SRC_IPO;
      internal_precision_osc_en_o <= 1'b1;
      primary_osc_en_o <= 1'b0;
      wdog_osc_en_o <= 1'b0;
      clock_fail_event_o <= 1'b0;
    end else begin
      clock_source_select_o <= next_failover ? oscc_pkg::SRC_WDOG : next_ctrl[oscc_pkg::SEL_LSB +: 2];
      internal_precision_osc_en_o <= next_ctrl[oscc_pkg::IPO_EN_BIT];
      primary_osc_en_o <= next_ctrl[oscc_pkg::PRI_EN_BIT];
      wdog_osc_en_o <= next_ctrl[oscc_pkg::WDO_EN_BIT] || next_failover;
      clock_fail_event_o <= next_failed;
    end
  end

  // assertions
  sequence s_key1;
    ctrl_wr && wb_dat_i[7:0] == oscc_pkg::KEY_FIRST && lock_state == oscc_pkg::LOCK_IDLE;
  endsequence
  sequence s_key2;
    ctrl_wr && wb_dat_i[7:0] == oscc_pkg::KEY_SECOND && lock_state == oscc_pkg::LOCK_KEY1;
  endsequence

  // progress lives in lock_state, so each key step is checked on its own edge
  a_unlock_order: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_key1 |=> lock_state == oscc_pkg::LOCK_KEY1)
    else $error("first key did not arm the unlock");
  a_unlock_open: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    s_key2 |=> lock_state == oscc_pkg::LOCK_OPEN)
    else $error("second key did not unlock");
  a_write_relock: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    ctrl_wr && lock_state == oscc_pkg::LOCK_OPEN
    |=> lock_state == oscc_pkg::LOCK_IDLE && osc_source_control_reg == $past(wb_dat_i[7:0]))
    else $error("open write not stored or not relocked");
  a_locked_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    lock_state != oscc_pkg::LOCK_OPEN |=> $stable(osc_source_control_reg))
    else $error("locked control register changed");
  a_progress_kept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    !ctrl_wr |=> $stable(lock_state))
    else $error("unlock progress changed without control write");
  a_ipo_sticky: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    internal_precision_osc_en_o && !(ctrl_wr && lock_state == oscc_pkg::LOCK_OPEN)
    |=> internal_precision_osc_en_o)
    else $error("precision osc switched off without software");
  a_fail_event: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    detect_fail && primary_fail_detect_enable |=> clock_fail_event_o)
    else $error("failure event missing");
  a_failover_sel: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    failover |-> clock_source_select_o == oscc_pkg::SRC_WDOG && wdog_osc_en_o)
    else $error("fail-over did not select watchdog osc");
  a_no_wdog_off: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    detect_fail && !osc_source_control_reg[oscc_pkg::WDO_EN_BIT] && !failover |=> !failover)
    else $error("fail-over with watchdog osc disabled");
  a_no_wdog_sel: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    clock_source_select == oscc_pkg::SRC_WDOG && !failover |=> !failover)
    else $error("fail-over while watchdog osc selected");
  a_trip_early: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    detect_fail |-> quiet_span >= 25'(TRIP))
    else $error("failure flagged before a full quiet window");
  a_trip_late: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    quiet_span >= 25'(TRIP) |-> detect_fail)
    else $error("full quiet window without a failure flag");
endmodule : oscc_top

// file: common/oscc_pkg.sv
// Purpose: constants for the oscillator control, lock and fail-over block
// Assumes: classic Wishbone slave with 32-bit data, one aligned word per register
// Notes: source select encodings are local to this block
package oscc_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_ADDR = 4'h0;  // oscillator control (locked)
  localparam logic [3:0] STAT_ADDR = 4'h4;  // status, read only
  localparam logic [3:0] SCRATCH_ADDR = 4'h8;  // plain scratch word
  // unlock keys
  localparam logic [7:0] KEY_FIRST = 8'he7;
  localparam logic [7:0] KEY_SECOND = 8'h18;
  // control field positions
  localparam int IPO_EN_BIT = 7;
  localparam int PRI_EN_BIT = 6;
  localparam int WDO_EN_BIT = 5;
  localparam int POF_EN_BIT = 3;
  localparam int WOF_EN_BIT = 2;
  localparam int SEL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h80;  // precision osc on, selected
  // clock source select codes
  localparam logic [1:0] SRC_IPO = 2'h0;
  localparam logic [1:0] SRC_PRIMARY = 2'h1;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_WDOG = 2'h3;
  // status field positions
  localparam int ST_FAILOVER_BIT = 0;
  localparam int ST_UNLOCK_LSB = 1;
  localparam int ST_FAIL_BIT = 3;
  // failure detection: no primary edge for a 1 ms window (either edge counts, so trips below about 500 Hz)
  localparam int CLK_HZ = 20000000;
  localparam int TRIP_HZ = 1000;
  localparam int TRIP_CYCLES = CLK_HZ / TRIP_HZ;
  // unlock sequencer states
  typedef enum logic [1:0] {
    LOCK_IDLE = 2'b00,
    LOCK_KEY1 = 2'b01,
    LOCK_OPEN = 2'b10
  } oscc_lock_t;
endpackage : oscc_pkg

// file: rtl/oscc_edge_watch.sv
// Purpose: watches the primary oscillator for missing edges
// Assumes: primary clock already sampled as a synchronous level
// Notes: trip window is a parameter so that a simulation may shorten it
`timescale 1ns/1ps
module oscc_edge_watch #(
  parameter int TRIP = oscc_pkg::TRIP_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic enable_i,
  input wire logic osc_i,
  output logic fail_o
);
  logic last;
  logic [24:0] count;
  logic next_last;
  logic [24:0] next_count;
  logic next_fail;

  // any edge restarts the window; a full window without one is a failure
  always_comb begin
    next_last = osc_i;
    next_count = count;
    next_fail = 1'b0;
    if (!enable_i || (osc_i != last)) begin
      next_count = '0;
    end else if (count >= 25'(TRIP - 1)) begin
      next_fail = 1'b1;
    end else begin
      next_count = count + 25'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      last <= 1'b0;
      count <= '0;
      fail_o <= 1'b0;
    end else begin
      last <= next_last;
      count <= next_count;
      fail_o <= next_fail;
    end
  end
endmodule : oscc_edge_watch

// file: sim/oscc_top_tb_top.sv
// Purpose: self-checking bench for the keyed oscillator control and fail-over block
// Assumes: classic Wishbone master driven here; trip window shortened to 16 cycles
// Notes: reads note their expected word in a queue, a monitor compares at each read ack
`timescale 1ns/1ps
module oscc_top_tb_top;
  localparam int TRIP_SIM = 16;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic primary_osc_i = 1'b0;
  logic osc_run = 1'b1;
  logic [1:0] sel_o;
  logic prec_en_o, pri_en_o, wdog_en_o, fail_ev_o;
  logic [15:0] lfsr = 16'hb020;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int num_checks = 0;

  oscc_top #(.TRIP(TRIP_SIM)) uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .primary_osc_i(primary_osc_i),
    .wdog_osc_ok_i(1'b0), .clock_source_select_o(sel_o), .internal_precision_osc_en_o(prec_en_o),
    .primary_osc_en_o(pri_en_o), .wdog_osc_en_o(wdog_en_o), .clock_fail_event_o(fail_ev_o));

  // 20 MHz system clock
  always #25 ref_clk_i = ~ref_clk_i;

  // primary oscillator model: toggles each cycle while running, frozen to fake a failure
  always @(posedge ref_clk_i) begin
    if (osc_run) primary_osc_i <= ~primary_osc_i;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // read monitor: every read ack consumes the oldest noted expectation
  always @(posedge ref_clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      check("read data", wb_dat_o, exp_q.pop_front());
    end
  end

  // one classic cycle; request held until ack is sampled high, then released
  task automatic xfer(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask : wr

  task automatic rd(input logic [3:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, adr, 32'h0);
  endtask : rd

  // full unlock then one effective control write
  task automatic setctl(input logic [7:0] v);
    wr(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::KEY_FIRST});
    wr(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::KEY_SECOND});
    wr(oscc_pkg::CTRL_ADDR, {24'h0, v});
  endtask : setctl

  // freeze or restart the primary clock, then look at settled outputs
  task automatic osc_wait(input logic run, input int cycles);
    osc_run <= run;
    repeat (cycles) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : osc_wait

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    miscompares++;
    complete_run();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(negedge ref_clk_i);
    check("select", {30'h0, sel_o}, 32'h0);
    check("prec en", {31'h0, prec_en_o}, 32'h1);
    check("event", {31'h0, fail_ev_o}, 32'h0);
    rd(oscc_pkg::STAT_ADDR, 32'h0);
    rd(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::CTRL_RESET});
    // locked writes and wrong key order change nothing
    wr(oscc_pkg::CTRL_ADDR, 32'h41);
    wr(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::KEY_SECOND});
    rd(oscc_pkg::STAT_ADDR, 32'h0);
    wr(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::KEY_FIRST});
    wr(oscc_pkg::CTRL_ADDR, 32'h55);
    rd(oscc_pkg::STAT_ADDR, 32'h0);
    rd(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::CTRL_RESET});
    wr(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::KEY_FIRST});
    rd(oscc_pkg::STAT_ADDR, 32'h2);
    lfsr = lfsr_next(lfsr);
    wr(oscc_pkg::SCRATCH_ADDR, {lfsr, ~lfsr});
    rd(oscc_pkg::SCRATCH_ADDR, {lfsr, ~lfsr});
    wr(4'hc, {~lfsr, lfsr});
    rd(4'hc, 32'h0);
    rd(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::CTRL_RESET});
    wr(oscc_pkg::CTRL_ADDR, {24'h0, oscc_pkg::KEY_SECOND});
    rd(oscc_pkg::STAT_ADDR, 32'h4);
    // effective write: all oscillators on, primary selected, then relock
    wr(oscc_pkg::CTRL_ADDR, 32'he1);
    rd(oscc_pkg::STAT_ADDR, 32'h0);
    wr(oscc_pkg::CTRL_ADDR, 32'h00);
    rd(oscc_pkg::CTRL_ADDR, 32'he1);
    @(negedge ref_clk_i);
    check("select", {30'h0, sel_o}, {30'h0, oscc_pkg::SRC_PRIMARY});
    check("prec en", {31'h0, prec_en_o}, 32'h1);
    check("pri en", {31'h0, pri_en_o}, 32'h1);
    // detection on, primary stops, fail-over to watchdog
    setctl(8'he9);
    rd(oscc_pkg::CTRL_ADDR, 32'he9);
    osc_wait(1'b0, TRIP_SIM - 2);
    check("event", {31'h0, fail_ev_o}, 32'h0);
    osc_wait(1'b0, 6);
    check("event", {31'h0, fail_ev_o}, 32'h1);
    check("select", {30'h0, sel_o}, {30'h0, oscc_pkg::SRC_WDOG});
    check("wdog en", {31'h0, wdog_en_o}, 32'h1);
    rd(oscc_pkg::STAT_ADDR, 32'h9);
    // watchdog oscillator off: event but no fail-over
    osc_wait(1'b1, 4);
    setctl(8'hc9);
    @(negedge ref_clk_i);
    check("event", {31'h0, fail_ev_o}, 32'h0);
    osc_wait(1'b0, TRIP_SIM + 4);
    check("event", {31'h0, fail_ev_o}, 32'h1);
    check("select", {30'h0, sel_o}, {30'h0, oscc_pkg::SRC_PRIMARY});
    check("wdog en", {31'h0, wdog_en_o}, 32'h0);
    rd(oscc_pkg::STAT_ADDR, 32'h8);
    // watchdog already selected: no fail-over recorded
    osc_wait(1'b1, 4);
    // detectors off before the select changes, re-enabled afterwards
    setctl(8'he1);
    setctl(8'he3);
    setctl(8'heb);
    osc_wait(1'b0, TRIP_SIM + 4);
    check("select", {30'h0, sel_o}, {30'h0, oscc_pkg::SRC_WDOG});
    rd(oscc_pkg::STAT_ADDR, 32'h8);
    // detection disabled: a dead primary raises nothing
    osc_wait(1'b1, 4);
    setctl(8'he3);
    // external source runs with primary detection kept off
    setctl(8'he2);
    osc_wait(1'b0, TRIP_SIM + 4);
    check("event", {31'h0, fail_ev_o}, 32'h0);
    check("select", {30'h0, sel_o}, {30'h0, oscc_pkg::SRC_EXTERNAL});
    rd(oscc_pkg::STAT_ADDR, 32'h0);
    repeat (4) @(posedge ref_clk_i);
    check("queue left", exp_q.size(), 32'h0);
    complete_run();
  end
endmodule : oscc_top_tb_top
